/* bench/eqiw_event_queue_irq_wdog_tb.sv */
// Self-checking testbench for the event flag, queue placement and watchdog block
`timescale 1ns/1ps
module eqiw_event_queue_irq_wdog_tb;
	import eqiw_pkg::*;
	localparam int TICK = 4;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	eqiw_bus_req_t req;
	logic [15:0] rdata;
	logic [13:0] ev = '0;
	logic ts = 1'b1;
	logic [15:0] txsel = 16'h0001;
	logic [2:0] qsel = 3'h1;
	logic irq;
	logic watchdog_out;
	logic [23:0] initiate_block_address, hq, mq, cq, e;
	logic [15:0] b, q, m, d;
	int n;
	int err_count = 0;
	int num_checks = 0;
	int seed = 32'hd604_6478;

	eqiw_host host_u (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

	eqiw_event_queue_irq_wdog #(.TICK_CYCLES(TICK)) dut_u (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(req.addr), .wdata_i(req.wdata),
		.wr_i(req.wr), .rd_i(req.rd), .hdlc_event_i(ev[0]), .ci_receive_event_i(ev[1]),
		.monitor_rx_event_i(ev[2]), .monitor_tx_irq_reg_i(ev[3] ? txsel : 16'h0000),
		.queue_full_i(ev[4] ? qsel : 3'h0), .rx_fifo_warning_i(ev[5]),
		.rx_fifo_overload_i(ev[6]), .tx_fifo_warning_i(ev[7]), .tx_fifo_overload_i(ev[8]),
		.irq_fifo_warning_i(ev[9]), .irq_fifo_overload_i(ev[10]),
		.prbs_recovered_event_i(ev[12]), .fault_count_i(ev[13] ? 16'hffff : 16'hfffe),
		.timestamp_enable_i(ts), .rdata_o(rdata), .irq_out_o(irq), .watchdog_out_o(watchdog_out),
		.initiate_block_address_o(initiate_block_address), .hdlc_queue_addr_o(hq), .monitor_queue_addr_o(mq),
		.ci_queue_addr_o(cq));

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
		num_checks++;
		if (got !== ex)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] ex);
		logic [15:0] v;
		host_u.rd_reg(a, v);
		chk(nm, {8'h00, ex}, {8'h00, v});
	endtask

	// Restart with a new period, release the timer and count edges up to the watchdog
	task automatic wdog_run(input logic [15:0] per, input int ticks, input string nm);
		host_u.wr_reg(EQIW_OFF_TIMER, per);
		host_u.restart();
		chk("wdog_idle", 24'h0, {23'h0, watchdog_out});
		ts <= 1'b0;
		n = 0;
		while (watchdog_out !== 1'b1 && n < 5000)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("wdog_fired", 24'h1, {23'h0, watchdog_out});
		chk(nm, 24'(ticks * TICK), 24'(n));
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	// Generous bound: the whole sequence needs a few thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		txsel = 16'h0001 << ($random(seed) & 15);
		qsel = 3'(($random(seed) & 3) + 1);
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1'b1;
		#1;
		chk("hdlc_q_rst", 24'h00_0100, hq);
		chk("mon_q_rst", 24'h00_0180, mq);
		chk("ci_q_rst", 24'h00_0200, cq);
		rchk("base_rst", EQIW_OFF_BASE, 16'h0000);
		rchk("qsize_rst", EQIW_OFF_QSIZE, 16'h0000);
		rchk("mask_rst", EQIW_OFF_MASK, 16'hffff);
		rchk("timer_rst", EQIW_OFF_TIMER, 16'h0800);
		rchk("unmapped", 8'h10, 16'h0000);
		// First pass uses the largest codes and top base to hit the wrap boundary
		for (int i = 0; i < 12; i++)
		begin
			b = (i == 0) ? 16'hffff : 16'($random(seed));
			q = (i == 0) ? 16'h00ff : 16'($random(seed));
			host_u.wr_reg(EQIW_OFF_BASE, b);
			host_u.wr_reg(EQIW_OFF_QSIZE, q);
			e = {b, 8'h00};
			chk("base_addr", e, initiate_block_address);
			e = e + 24'd256;
			chk("hdlc_q", e, hq);
			e = e + 24'(128 * (int'(q[7:5]) + 1));
			chk("mon_q", e, mq);
			e = e + 24'(128 * (int'(q[4:2]) + 1));
			chk("ci_q", e, cq);
			rchk("qsize_rd", EQIW_OFF_QSIZE, {8'h00, q[7:0]});
		end
		host_u.wr_reg(EQIW_OFF_FLAGS, 16'hffff);
		rchk("flags_ro", EQIW_OFF_FLAGS, 16'h0000);
		// Timer frozen by time stamping so only the pulsed source shows
		for (int i = 0; i < 14; i++)
		begin
			if (i == EQIW_EV_TIMER)
				continue;
			@(posedge clk_i);
			ev <= 14'h0001 << i;
			@(posedge clk_i);
			ev <= '0;
			host_u.wr_reg(EQIW_OFF_MASK, 16'hffff);
			chk("irq_masked", 24'h0, {23'h0, irq});
			m = 16'($random(seed)) & ~(16'h0001 << i);
			host_u.wr_reg(EQIW_OFF_MASK, m);
			chk("irq_open", 24'h1, {23'h0, irq});
			rchk("mask_rd", EQIW_OFF_MASK, m & 16'h3fff);
			rchk("flags", EQIW_OFF_FLAGS, 16'h0001 << i);
			chk("irq_clr", 24'h0, {23'h0, irq});
			rchk("flags_empty", EQIW_OFF_FLAGS, 16'h0000);
		end
		host_u.wr_reg(EQIW_OFF_MASK, 16'hf7ff);
		host_u.rd_reg(EQIW_OFF_FLAGS, d);
		// Two milliseconds first, one second and one millisecond last
		wdog_run(16'h000b, 2, "wdog_ms");
		@(posedge clk_i);
		#1;
		chk("irq_timer", 24'h1, {23'h0, irq});
		rchk("flags_timer", EQIW_OFF_FLAGS, 16'h0800);
		rchk("timer_rd", EQIW_OFF_TIMER, 16'h000b);
		ts <= 1'b1;
		host_u.restart();
		chk("wdog_restart", 24'h0, {23'h0, watchdog_out});
		host_u.rd_reg(EQIW_OFF_FLAGS, d);
		repeat (100) @(posedge clk_i);
		#1;
		chk("wdog_frozen", 24'h0, {23'h0, watchdog_out});
		rchk("flags_frozen", EQIW_OFF_FLAGS, 16'h0000);
		wdog_run(16'h1004, 1001, "wdog_sec");
		rchk("flags_sec", EQIW_OFF_FLAGS, 16'h0800);
		stop_test();
	end
endmodule

/* bench/eqiw_host.sv */
// Host processor model: drives the register bus of the event block
`timescale 1ns/1ps
module eqiw_host
	import eqiw_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output eqiw_bus_req_t req_o
);
	// ****************************************
	// Bus cycles, one strobe cycle each
	// ****************************************
	initial req_o = '0;

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		req_o.wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		req_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		req_o.rd <= 1'b0;
		#1;
		d = rdata_i;
	endtask

	// Keeps the watchdog from firing
	task automatic restart();
		wr_reg(EQIW_OFF_CTRL, 16'h0001);
	endtask
endmodule

/* hw/eqiw_event_queue_irq_wdog.sv */
// Event flags, masks, queue placement and watchdog timer for the line card
`timescale 1ns/1ps
// How it works
// - Base register gives address bits 23..8
// - HDLC queue starts at base plus 256
// - Monitor queue follows the HDLC queue
// - Command/indicate queue follows the monitor queue
// - HDLC queue is 128 words per code step
// - Monitor queue uses the same 128-word steps
// - Command/indicate queue is 64 words per step
// - Flag register read returns then clears all, except flags set again in the read cycle
// - Interrupt output high for any unmasked flag
// - Mask bits 0..13 each suppress one flag
// - HDLC event sets HDLC flag
// - Command/indicate receive event sets its flag
// - Monitor receive event sets its flag
// - Transmit monitor events set monitor transmit flag
// - Any full memory queue sets overload flag
// - Three-quarter FIFO levels set warning flags
// - Full DMA FIFOs set overload flags
// - Full status FIFO sets its overload flag
// - Recovered pseudo-random sequence sets its flag
// - Fault counter at FFFF sets overflow flag
// - Missed restart drives watchdog output high
// - Each unrestarted period raises the timer flag
// - Time stamping enabled ignores the period register
module eqiw_event_queue_irq_wdog
	import eqiw_pkg::*;
#(
	parameter int TICK_CYCLES = EQIW_TICK_CYC
)
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic hdlc_event_i,
	input wire logic ci_receive_event_i,
	input wire logic monitor_rx_event_i,
	input wire logic [15:0] monitor_tx_irq_reg_i,
	input wire logic [2:0] queue_full_i,
	input wire logic rx_fifo_warning_i,
	input wire logic rx_fifo_overload_i,
	input wire logic tx_fifo_warning_i,
	input wire logic tx_fifo_overload_i,
	input wire logic irq_fifo_warning_i,
	input wire logic irq_fifo_overload_i,
	input wire logic prbs_recovered_event_i,
	input wire logic [15:0] fault_count_i,
	input wire logic timestamp_enable_i,
	output logic [15:0] rdata_o,
	output logic irq_out_o,
	output logic watchdog_out_o,
	output logic [23:0] initiate_block_address_o,
	output logic [23:0] hdlc_queue_addr_o,
	output logic [23:0] monitor_queue_addr_o,
	output logic [23:0] ci_queue_addr_o
);

	// ****************************************
	// Types and helpers
	// ****************************************
	typedef struct packed {
		logic [15:0] base;
		logic [15:0] qsize;
		logic [15:0] flags;
		logic [15:0] mask;
		logic [15:0] period;
		logic [15:0] rdata;
		logic irq;
		logic wdog;
		logic [15:0] tick_cnt;
		logic [3:0] sec_cnt;
		logic [9:0] ms_cnt;
		logic fault_seen;
		eqiw_queue_map_t qmap;
	} eqiw_state_t;

	// Queue size in words from a size code and its step
	function automatic logic [23:0] eqiw_qwords(input logic [2:0] code, input logic [10:0] unit);
		logic [13:0] prod;
		prod = 14'({11'h000, code} + 14'h0001) * 14'(unit);
		return {10'h000, prod};
	endfunction

	eqiw_state_t st_r;
	eqiw_state_t st_nxt;
	eqiw_sources_t src;
	logic [EQIW_NUM_EVENTS-1:0] ev_set;
	logic fault_hit;
	logic period_done;
	logic tick;
	logic ms_wrap;
	logic [9:0] ms_next;
	logic [3:0] sec_next;

	// ****************************************
	// Event sources
	// ****************************************
	always_comb
	begin
		src.hdlc = hdlc_event_i;
		src.ci_rx = ci_receive_event_i;
		src.mon_rx = monitor_rx_event_i;
		src.mon_tx = |monitor_tx_irq_reg_i;
		src.queue_full = |queue_full_i;
		src.rx_fifo_warn = rx_fifo_warning_i;
		src.rx_fifo_full = rx_fifo_overload_i;
		src.tx_fifo_warn = tx_fifo_warning_i;
		src.tx_fifo_full = tx_fifo_overload_i;
		src.irq_fifo_warn = irq_fifo_warning_i;
		src.irq_fifo_full = irq_fifo_overload_i;
		src.prbs_recovered = prbs_recovered_event_i;
	end

	// Fault flag fires once on arrival at the limit, not every cycle it sits there
	assign fault_hit = (fault_count_i == EQIW_FAULT_LIMIT) && !st_r.fault_seen;

	// Timer runs on a 1 ms tick from the system clock
	assign tick = (st_r.tick_cnt == 16'(TICK_CYCLES - 1));
	assign ms_wrap = (st_r.ms_cnt == 10'(EQIW_MS_PER_S - 1));
	assign ms_next = ms_wrap ? 10'h000 : st_r.ms_cnt + 10'h001;
	assign sec_next = ms_wrap ? st_r.sec_cnt + 4'h1 : st_r.sec_cnt;
	// Period ends on the tick that brings elapsed time up to the programmed value
	// Zero ends on every tick; a milliseconds field above 999 never ends a period
	assign period_done = tick && !timestamp_enable_i
		&& ((st_r.period[15:2] == 14'h0000)
		|| ((sec_next == st_r.period[15:12]) && (ms_next == st_r.period[11:2])));

	always_comb
	begin
		ev_set = '0;
		ev_set[0] = src.hdlc;
		ev_set[1] = src.ci_rx;
		ev_set[2] = src.mon_rx;
		ev_set[3] = src.mon_tx;
		ev_set[4] = src.queue_full;
		ev_set[5] = src.rx_fifo_warn;
		ev_set[6] = src.rx_fifo_full;
		ev_set[7] = src.tx_fifo_warn;
		ev_set[8] = src.tx_fifo_full;
		ev_set[9] = src.irq_fifo_warn;
		ev_set[10] = src.irq_fifo_full;
		ev_set[EQIW_EV_TIMER] = period_done;
		ev_set[12] = src.prbs_recovered;
		ev_set[13] = fault_hit;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic restart;
		logic [15:0] flags_cur;
		restart = 1'b0;
		flags_cur = st_r.flags;
		st_nxt = st_r;
		st_nxt.fault_seen = (fault_count_i == EQIW_FAULT_LIMIT);
		st_nxt.rdata = 16'h0000;
		if (rd_i)
		begin
			unique case (addr_i)
				EQIW_OFF_BASE: st_nxt.rdata = st_r.base;
				EQIW_OFF_QSIZE: st_nxt.rdata = st_r.qsize;
				EQIW_OFF_FLAGS:
				begin
					st_nxt.rdata = st_r.flags;
					flags_cur = 16'h0000;
				end
				EQIW_OFF_MASK: st_nxt.rdata = st_r.mask;
				EQIW_OFF_TIMER: st_nxt.rdata = st_r.period;
				EQIW_OFF_STATUS: st_nxt.rdata = {14'h0000, st_r.wdog, st_r.irq};
				default: st_nxt.rdata = 16'h0000;
			endcase
		end
		if (wr_i)
		begin
			unique case (addr_i)
				EQIW_OFF_BASE: st_nxt.base = wdata_i;
				EQIW_OFF_QSIZE: st_nxt.qsize = {8'h00, wdata_i[7:0]};
				EQIW_OFF_MASK: st_nxt.mask = {2'b00, wdata_i[13:0]};
				EQIW_OFF_TIMER: st_nxt.period = wdata_i;
				EQIW_OFF_CTRL: restart = wdata_i[0];
				default: st_nxt.period = st_nxt.period;
			endcase
		end
		// Sets win over the clear-on-read
		st_nxt.flags = flags_cur | {2'b00, ev_set};
		// Timer counting; a restart or end of period starts a fresh period
		if (restart || period_done)
		begin
			st_nxt.tick_cnt = 16'h0000;
			st_nxt.ms_cnt = 10'h000;
			st_nxt.sec_cnt = 4'h0;
		end
		else if (!timestamp_enable_i)
		begin
			if (tick)
			begin
				st_nxt.tick_cnt = 16'h0000;
				if (st_r.ms_cnt == 10'(EQIW_MS_PER_S - 1))
				begin
					st_nxt.ms_cnt = 10'h000;
					st_nxt.sec_cnt = st_r.sec_cnt + 4'h1;
				end
				else
				begin
					st_nxt.ms_cnt = st_r.ms_cnt + 10'h001;
				end
			end
			else
			begin
				st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
			end
		end
		// Watchdog latches until the processor restarts it
		if (restart)
			st_nxt.wdog = 1'b0;
		else if (period_done)
			st_nxt.wdog = 1'b1;
		st_nxt.irq = |(st_nxt.flags[EQIW_NUM_EVENTS-1:0] & ~st_nxt.mask[EQIW_NUM_EVENTS-1:0]);
		st_nxt.qmap.base_addr = {st_nxt.base, 8'h00};
		st_nxt.qmap.hdlc_q_addr = st_nxt.qmap.base_addr + EQIW_QUEUE_OFFSET;
		st_nxt.qmap.mon_q_addr = st_nxt.qmap.hdlc_q_addr
			+ eqiw_qwords(st_nxt.qsize[EQIW_HDLC_SZ_LSB +: 3], EQIW_BIG_QUEUE_UNIT);
		st_nxt.qmap.ci_q_addr = st_nxt.qmap.mon_q_addr
			+ eqiw_qwords(st_nxt.qsize[EQIW_MON_SZ_LSB +: 3], EQIW_BIG_QUEUE_UNIT);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r <= '0;
			st_r.base <= EQIW_RST_BASE;
			st_r.qsize <= EQIW_RST_QSIZE;
			st_r.flags <= EQIW_RST_FLAGS;
			st_r.mask <= EQIW_RST_MASK;
			st_r.period <= EQIW_RST_TIMER;
			st_r.qmap.hdlc_q_addr <= EQIW_QUEUE_OFFSET;
			st_r.qmap.mon_q_addr <= EQIW_QUEUE_OFFSET + {13'h0000, EQIW_BIG_QUEUE_UNIT};
			st_r.qmap.ci_q_addr <= EQIW_QUEUE_OFFSET + {12'h000, EQIW_BIG_QUEUE_UNIT, 1'b0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign irq_out_o = st_r.irq;
	assign watchdog_out_o = st_r.wdog;
	assign initiate_block_address_o = st_r.qmap.base_addr;
	assign hdlc_queue_addr_o = st_r.qmap.hdlc_q_addr;
	assign monitor_queue_addr_o = st_r.qmap.mon_q_addr;
	// Command/indicate queue size is computed here only for the a_ci_size check; no output carries it
	logic [23:0] ci_q_size;
	assign ci_q_size = eqiw_qwords({1'b0, st_r.qsize[EQIW_CI_SZ_LSB +: 2]}, EQIW_CI_QUEUE_UNIT);
	assign ci_queue_addr_o = st_r.qmap.ci_q_addr;

	// ****************************************
	// Checks
	// ****************************************
	property p_flag_read_clears;
		@(posedge clk_i) disable iff (!arst_n_i)
		(rd_i && addr_i == EQIW_OFF_FLAGS) |=> (rdata_o == $past(st_r.flags))
			&& ((st_r.flags & ~{2'b00, $past(ev_set)}) == 16'h0000);
	endproperty
	a_flag_read_clears: assert property (p_flag_read_clears) else $error("flag read did not clear");

	property p_irq_level;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_out_o == |(st_r.flags[13:0] & ~st_r.mask[13:0]);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq output mismatch");

	property p_mask_upper_zero;
		@(posedge clk_i) disable iff (!arst_n_i)
		(wr_i && addr_i == EQIW_OFF_MASK) |=> st_r.mask[15:14] == 2'b00;
	endproperty
	a_mask_upper_zero: assert property (p_mask_upper_zero) else $error("mask high bits set");

	property p_hdlc_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		hdlc_event_i |=> st_r.flags[0];
	endproperty
	a_hdlc_sets: assert property (p_hdlc_sets) else $error("hdlc flag not set");

	property p_mon_tx_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		(|monitor_tx_irq_reg_i) |=> st_r.flags[3];
	endproperty
	a_mon_tx_sets: assert property (p_mon_tx_sets) else $error("monitor tx flag not set");

	property p_queue_chain;
		@(posedge clk_i) disable iff (!arst_n_i)
		(hdlc_queue_addr_o == initiate_block_address_o + 24'h00_0100)
			&& (initiate_block_address_o[7:0] == 8'h00);
	endproperty
	a_queue_chain: assert property (p_queue_chain) else $error("hdlc queue address wrong");

	property p_wdog_on_period;
		@(posedge clk_i) disable iff (!arst_n_i)
		(period_done && !(wr_i && addr_i == EQIW_OFF_CTRL && wdata_i[0]))
			|=> watchdog_out_o && st_r.flags[11];
	endproperty
	a_wdog_on_period: assert property (p_wdog_on_period) else $error("watchdog not raised");

	property p_tstamp_freezes;
		@(posedge clk_i) disable iff (!arst_n_i)
		timestamp_enable_i |-> !period_done;
	endproperty
	a_tstamp_freezes: assert property (p_tstamp_freezes) else $error("timer ran in stamp mode");

	property p_ci_size;
		@(posedge clk_i) disable iff (!arst_n_i)
		ci_q_size == 24'(({22'h0, st_r.qsize[1:0]} + 24'h1) * 24'h40);
	endproperty
	a_ci_size: assert property (p_ci_size) else $error("ci queue size wrong");

	sequence s_restart_wr;
		wr_i && (addr_i == EQIW_OFF_CTRL) && wdata_i[0];
	endsequence

	property p_restart_clears;
		@(posedge clk_i) disable iff (!arst_n_i)
		s_restart_wr |=> !watchdog_out_o;
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("watchdog not cleared");

	property p_ci_rx_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		ci_receive_event_i |=> st_r.flags[1];
	endproperty
	a_ci_rx_sets: assert property (p_ci_rx_sets) else $error("ci receive flag not set");

	property p_mon_rx_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		monitor_rx_event_i |=> st_r.flags[2];
	endproperty
	a_mon_rx_sets: assert property (p_mon_rx_sets) else $error("monitor rx flag not set");

	property p_queue_full_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		(|queue_full_i) |=> st_r.flags[4];
	endproperty
	a_queue_full_sets: assert property (p_queue_full_sets) else $error("overload flag not set");

	property p_rx_warn_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		rx_fifo_warning_i |=> st_r.flags[5];
	endproperty
	a_rx_warn_sets: assert property (p_rx_warn_sets) else $error("rx warning flag not set");

	property p_irq_fifo_full_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		irq_fifo_overload_i |=> st_r.flags[10];
	endproperty
	a_irq_fifo_full_sets: assert property (p_irq_fifo_full_sets) else $error("status fifo flag not set");

	property p_prbs_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		prbs_recovered_event_i |=> st_r.flags[12];
	endproperty
	a_prbs_sets: assert property (p_prbs_sets) else $error("prbs flag not set");

	// Counter arriving at the limit from below
	sequence s_fault_arrive;
		(fault_count_i != EQIW_FAULT_LIMIT) ##1 (fault_count_i == EQIW_FAULT_LIMIT);
	endsequence

	property p_fault_sets;
		@(posedge clk_i) disable iff (!arst_n_i)
		s_fault_arrive |=> st_r.flags[13];
	endproperty
	a_fault_sets: assert property (p_fault_sets) else $error("fault overflow flag not set");

	property p_mon_q_step;
		@(posedge clk_i) disable iff (!arst_n_i)
		(monitor_queue_addr_o - hdlc_queue_addr_o)
			== ({21'h00_0000, st_r.qsize[7:5]} + 24'h00_0001) * 24'h00_0080;
	endproperty
	a_mon_q_step: assert property (p_mon_q_step) else $error("monitor queue offset wrong");

endmodule

/* hw/eqiw_pkg.sv */
// Package: register map, field layout, reset values and timing constants
package eqiw_pkg;

	localparam logic [7:0] EQIW_OFF_BASE = 8'h34;
	localparam logic [7:0] EQIW_OFF_QSIZE = 8'h36;
	localparam logic [7:0] EQIW_OFF_FLAGS = 8'h38;
	localparam logic [7:0] EQIW_OFF_MASK = 8'h3a;
	localparam logic [7:0] EQIW_OFF_TIMER = 8'h3c;
	localparam logic [7:0] EQIW_OFF_CTRL = 8'h40;
	localparam logic [7:0] EQIW_OFF_STATUS = 8'h42;

	localparam logic [15:0] EQIW_RST_BASE = 16'h0000;
	localparam logic [15:0] EQIW_RST_QSIZE = 16'h0000;
	localparam logic [15:0] EQIW_RST_FLAGS = 16'h0000;
	localparam logic [15:0] EQIW_RST_MASK = 16'hffff;
	localparam logic [15:0] EQIW_RST_TIMER = 16'h0800;

	localparam int EQIW_NUM_EVENTS = 14;
	localparam int EQIW_HDLC_SZ_LSB = 5;
	localparam int EQIW_MON_SZ_LSB = 2;
	localparam int EQIW_CI_SZ_LSB = 0;
	localparam int EQIW_TMR_SEC_LSB = 12;
	localparam int EQIW_TMR_MS_LSB = 2;
	localparam int EQIW_EV_TIMER = 11;

	localparam logic [23:0] EQIW_QUEUE_OFFSET = 24'h00_0100;
	localparam logic [10:0] EQIW_BIG_QUEUE_UNIT = 11'h080;
	localparam logic [10:0] EQIW_CI_QUEUE_UNIT = 11'h040;
	localparam logic [15:0] EQIW_FAULT_LIMIT = 16'hffff;

	localparam int EQIW_CLK_HZ = 50_000_000;
	localparam int EQIW_TICK_US = 1000;
	localparam int EQIW_TICK_CYC = EQIW_CLK_HZ / 1_000_000 * EQIW_TICK_US;
	localparam int EQIW_MS_PER_S = 1000;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} eqiw_bus_req_t;

	typedef struct packed {
		logic [23:0] base_addr;
		logic [23:0] hdlc_q_addr;
		logic [23:0] mon_q_addr;
		logic [23:0] ci_q_addr;
	} eqiw_queue_map_t;

	typedef struct packed {
		logic hdlc;
		logic ci_rx;
		logic mon_rx;
		logic mon_tx;
		logic queue_full;
		logic rx_fifo_warn;
		logic rx_fifo_full;
		logic tx_fifo_warn;
		logic tx_fifo_full;
		logic irq_fifo_warn;
		logic irq_fifo_full;
		logic prbs_recovered;
	} eqiw_sources_t;

endpackage
